// ---- rtl/swr_pkg.sv ----
// Package for the sleep, wake-up and reset-cause block.
// Assumes a single always-running 200 MHz system clock.
package swr_pkg;

	// System clock period
	localparam int unsigned CLK_PERIOD_NS = 5;

	// Nominal watchdog period without prescaler, and its cycle count
	localparam longint unsigned WDT_PERIOD_NS = 64'd18_000_000;
	localparam logic [31:0] WDT_PERIOD_CYCLES =
		32'(WDT_PERIOD_NS / CLK_PERIOD_NS);

	// Register byte offsets on the Avalon-MM slave
	localparam logic [3:0] REG_CTRL_OFS = 4'h0;
	localparam logic [3:0] REG_STATUS_OFS = 4'h4;
	localparam logic [3:0] REG_WAKE_REF_OFS = 4'h8;

	// Control register fields
	localparam int unsigned CTRL_WDT_EN_BIT = 0;
	localparam int unsigned CTRL_PIN_WAKE_EN_BIT = 1;
	localparam int unsigned CTRL_CMP_WAKE_EN_BIT = 2;
	localparam int unsigned CTRL_PSA_BIT = 3;
	localparam int unsigned CTRL_PS_LSB = 4;
	localparam int unsigned CTRL_MASTER_CLEAR_PIN_EN_BIT = 7;
	localparam logic [7:0] CTRL_RESET = 8'hff;

	// Status register fields
	localparam int unsigned STAT_PD_BIT = 0;
	localparam int unsigned STAT_TO_BIT = 1;
	localparam int unsigned STAT_PINW_BIT = 2;
	localparam int unsigned STAT_CMPW_BIT = 3;
	localparam int unsigned STAT_ASLEEP_BIT = 4;

	// Number of synchronised inputs: pins a, b, c, comparator, clear
	localparam int unsigned SYNC_W = 5;
	localparam logic [SYNC_W-1:0] SYNC_RESET = 5'h10;

	// Power state of the core
	typedef enum logic {
		SWR_AWAKE,
		SWR_ASLEEP
	} swr_state_e;

endpackage : swr_pkg

// ---- rtl/swr_sleep_wake.sv ----
// Sleep entry, wake-up detection, watchdog and reset-cause flags.
// Assumes clk_sys_i keeps running while the core oscillator is off;
// the core clock is gated from osc_drive_en_o outside this block.
//
// Summary of operation
// - Sleep clears but keeps watchdog, sets timeout, clears powerdown, stops oscillator.
// - While asleep the I/O ports hold their earlier drive state.
// - A watchdog reset never drives the master clear pin low.
// - With pin wake enabled, a watched pin change wakes the device.
// - With comparator wake enabled, a comparator output change wakes it.
// - Every wake-up event produces a full device reset.
// - A watchdog time-out clears the timeout flag unless a clear-pin fall comes in the same cycle.
// - Powerdown flag is set by power-up, cleared by sleep.
// - Pin reference is captured at each port access; pin flag shows a mismatch that woke the device.
// - Mismatch present at sleep entry wakes the device at once.
// - Watchdog count is cleared on every wake-up.
// - Watchdog wake from sleep: all four flags read 0.
// - Watchdog time-out awake: wake and timeout flags 0, powerdown kept.
// - Clear-pin wake: wake flags 0, timeout 1, powerdown 0.
// - Clear-pin reset awake: wake flags 0, timeout and powerdown kept.
// - Pin wake: comparator flag 0, pin flag 1, timeout 1, powerdown 0.
// - Comparator wake: comparator flag 1, pin flag 0, timeout 1, powerdown 0.
// - Flags hold until a reset or sleep entry; a clear pulse alone changes nothing else.
// - Sleep also clears the prescaler when assigned to the watchdog.
`timescale 1ns/10ps
`default_nettype none

module swr_sleep_wake
	import swr_pkg::*;
#(
	parameter logic [31:0] WDT_CYCLES = WDT_PERIOD_CYCLES
) (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// Core events
	input wire logic sleep_exec_i,
	input wire logic wdt_clear_i,
	input wire logic port_access_i,
	// Pins and comparator from outside the clock domain
	input wire logic watched_pin_a_i,
	input wire logic watched_pin_b_i,
	input wire logic watched_pin_c_i,
	input wire logic comparator_out_i,
	input wire logic master_clear_pin_n_i,
	// Avalon-MM slave
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// Power and reset controls
	output logic device_reset_o,
	output logic osc_drive_en_o,
	output logic io_hold_o,
	output logic asleep_o,
	output logic timeout_flag_o,
	output logic powerdown_flag_o,
	output logic pin_wake_flag_o,
	output logic comparator_wake_flag_o
);

	// Synchroniser stages
	logic [SYNC_W-1:0] sync1_q;
	logic [SYNC_W-1:0] sync2_q;
	logic [SYNC_W-1:0] async_in;

	// Watchdog
	logic [31:0] wdt_cnt_q;
	logic [7:0] presc_q;
	logic wdt_tick;
	logic wdt_timeout;
	logic wdt_clear;

	// Control and state
	logic [7:0] ctrl_q;
	swr_state_e state_q;
	logic [2:0] pin_ref_q;
	logic cmp_ref_q;
	logic master_clear_pin_low_prev_q;
	logic [SYNC_W-1:0] sync_view;

	// Events
	logic [2:0] pins_now;
	logic cmp_now;
	logic master_clear_pin_low;
	logic master_clear_pin_fall;
	logic pin_wake;
	logic cmp_wake;
	logic any_wake;

	// Flag registers
	logic to_q;
	logic pd_q;
	logic pinw_q;
	logic cmpw_q;
	logic rst_out_q;

	// Bus
	logic bus_req;
	logic wait_q;
	logic [31:0] rdata_q;

	assign async_in = {master_clear_pin_n_i, comparator_out_i,
		watched_pin_c_i, watched_pin_b_i, watched_pin_a_i};

	// Two-flop synchronisers; only the second stage is used below
	genvar gi;
	generate
		for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
			always_ff @(posedge clk_sys_i) begin
				if (!rst_n_i) begin
					sync1_q[gi] <= SYNC_RESET[gi];
					sync2_q[gi] <= SYNC_RESET[gi];
				end else begin
					sync1_q[gi] <= async_in[gi];
					sync2_q[gi] <= sync1_q[gi];
				end
			end
		end
	endgenerate

	assign sync_view = sync2_q;
	assign pins_now = sync_view[2:0];
	assign cmp_now = sync_view[3];
	// Clear pin only acts when enabled as master clear
	assign master_clear_pin_low = ctrl_q[CTRL_MASTER_CLEAR_PIN_EN_BIT] & ~sync_view[4];
	assign master_clear_pin_fall = master_clear_pin_low & ~master_clear_pin_low_prev_q;

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			master_clear_pin_low_prev_q <= 1'b0;
		end else begin
			master_clear_pin_low_prev_q <= master_clear_pin_low;
		end
	end

	// Wake detectors on the always-on clock, not the core oscillator
	assign pin_wake = (state_q == SWR_ASLEEP) &
		ctrl_q[CTRL_PIN_WAKE_EN_BIT] & (pins_now != pin_ref_q);
	assign cmp_wake = (state_q == SWR_ASLEEP) &
		ctrl_q[CTRL_CMP_WAKE_EN_BIT] & (cmp_now != cmp_ref_q);
	assign any_wake = (state_q == SWR_ASLEEP) &
		(master_clear_pin_fall | wdt_timeout | pin_wake | cmp_wake);

	// Watchdog cleared by software, sleep and any wake-up
	assign wdt_clear = wdt_clear_i | sleep_exec_i | any_wake | master_clear_pin_low;

	// Base counter: one tick per nominal period
	assign wdt_tick = ctrl_q[CTRL_WDT_EN_BIT] &
		(wdt_cnt_q == WDT_CYCLES - 32'h1);

	// Time-out on tick, or on prescaler wrap when it is assigned
	assign wdt_timeout = wdt_tick & (!ctrl_q[CTRL_PSA_BIT] |
		(presc_q == ((8'h1 << ctrl_q[CTRL_PS_LSB +: 3]) - 8'h1)));

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			wdt_cnt_q <= 32'h0;
		end else if (wdt_clear || wdt_tick ||
			!ctrl_q[CTRL_WDT_EN_BIT]) begin
			wdt_cnt_q <= 32'h0;
		end else begin
			wdt_cnt_q <= wdt_cnt_q + 32'h1; // Keeps running in sleep
		end
	end

	// Prescaler; a wrap restarts it for the next period
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			presc_q <= 8'h0;
		end else if (wdt_clear || wdt_timeout ||
			!ctrl_q[CTRL_PSA_BIT]) begin
			presc_q <= 8'h0;
		end else if (wdt_tick) begin
			presc_q <= presc_q + 8'h1;
		end
	end

	// Sleep state; any wake-up event returns it to awake directly
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			state_q <= SWR_AWAKE;
		end else begin
			case (state_q)
				SWR_AWAKE: begin
					if (sleep_exec_i && !master_clear_pin_low && !wdt_timeout) begin
						state_q <= SWR_ASLEEP;
					end
				end
				SWR_ASLEEP: begin
					if (any_wake) begin
						state_q <= SWR_AWAKE;
					end
				end
				default: begin
					state_q <= SWR_AWAKE;
				end
			endcase
		end
	end

	// Pin reference follows each port access comparator at entry
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			pin_ref_q <= 3'h0;
			cmp_ref_q <= 1'b0;
		end else begin
			if (port_access_i) begin
				pin_ref_q <= pins_now;
			end
			if (state_q == SWR_AWAKE) begin
				cmp_ref_q <= cmp_now;
			end
		end
	end

	// Reset-cause flags; clear pin outranks watchdog, pin, comparator
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			to_q <= 1'b1;
			pd_q <= 1'b1;
			pinw_q <= 1'b0;
			cmpw_q <= 1'b0;
		end else if (master_clear_pin_fall) begin
			pinw_q <= 1'b0;
			cmpw_q <= 1'b0;
			if (state_q == SWR_ASLEEP) begin
				to_q <= 1'b1;
				pd_q <= 1'b0;
			end
		end else if (wdt_timeout) begin
			to_q <= 1'b0;
			pinw_q <= 1'b0;
			cmpw_q <= 1'b0;
			if (state_q == SWR_ASLEEP) begin
				pd_q <= 1'b0;
			end
		end else if (pin_wake) begin
			cmpw_q <= 1'b0;
			pinw_q <= 1'b1;
			to_q <= 1'b1;
			pd_q <= 1'b0;
		end else if (cmp_wake) begin
			cmpw_q <= 1'b1;
			pinw_q <= 1'b0;
			to_q <= 1'b1;
			pd_q <= 1'b0;
		end else if (sleep_exec_i && state_q == SWR_AWAKE &&
			!master_clear_pin_low) begin
			to_q <= 1'b1;
			pd_q <= 1'b0;
		end
		// Otherwise all four hold
	end

	// Device reset: one cycle per event, held while clear pin is low.
	// This is an internal line only; nothing here drives the clear pin,
	// so a watchdog reset leaves that pin alone.
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			rst_out_q <= 1'b0;
		end else begin
			rst_out_q <= master_clear_pin_low | wdt_timeout | any_wake;
		end
	end

	// Avalon-MM: one wait cycle, then the request completes
	assign bus_req = avs_read_i | avs_write_i;

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			wait_q <= 1'b1;
		end else begin
			wait_q <= !(bus_req && wait_q);
		end
	end

	// Read data prepared during the wait cycle; unmapped reads give 0
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			rdata_q <= 32'h0;
		end else if (avs_read_i && wait_q) begin
			case (avs_address_i)
				REG_CTRL_OFS: rdata_q <= {24'h0, ctrl_q};
				REG_STATUS_OFS: begin
					rdata_q <= 32'h0;
					rdata_q[STAT_PD_BIT] <= pd_q;
					rdata_q[STAT_TO_BIT] <= to_q;
					rdata_q[STAT_PINW_BIT] <= pinw_q;
					rdata_q[STAT_CMPW_BIT] <= cmpw_q;
					rdata_q[STAT_ASLEEP_BIT] <= (state_q == SWR_ASLEEP);
				end
				REG_WAKE_REF_OFS: rdata_q <= {27'h0, cmp_ref_q, 1'b0,
					pin_ref_q};
				default: rdata_q <= 32'h0;
			endcase
		end
	end

	// Control write on the completing edge, low byte lane only
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			ctrl_q <= CTRL_RESET;
		end else if (avs_write_i && !wait_q &&
			avs_address_i == REG_CTRL_OFS && avs_byteenable_i[0]) begin
			ctrl_q <= avs_writedata_i[7:0];
		end
	end

	// Oscillator and port hold follow the sleep state
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			osc_drive_en_o <= 1'b1;
			io_hold_o <= 1'b0;
			asleep_o <= 1'b0;
		end else begin
			osc_drive_en_o <= (state_q == SWR_AWAKE);
			io_hold_o <= (state_q == SWR_ASLEEP);
			asleep_o <= (state_q == SWR_ASLEEP);
		end
	end

	// Remaining outputs straight from their flops
	assign avs_readdata_o = rdata_q;
	assign avs_waitrequest_o = wait_q;
	assign device_reset_o = rst_out_q;
	assign timeout_flag_o = to_q;
	assign powerdown_flag_o = pd_q;
	assign pin_wake_flag_o = pinw_q;
	assign comparator_wake_flag_o = cmpw_q;

endmodule // swr_sleep_wake

`default_nettype wire

// ---- tb/swr_sleep_wake_asserts.sv ----
// Checker for the sleep, wake and reset-cause block.
// Sees only the top ports; attached by the bind at the foot.
`timescale 1ns/10ps
`default_nettype none
module swr_sleep_wake_chk (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic sleep_exec_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic avs_waitrequest_o,
	input wire logic device_reset_o,
	input wire logic osc_drive_en_o,
	input wire logic io_hold_o,
	input wire logic asleep_o,
	input wire logic timeout_flag_o,
	input wire logic powerdown_flag_o,
	input wire logic pin_wake_flag_o,
	input wire logic comparator_wake_flag_o
);
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!rst_n_i);
	// Wake causes show as a rising cause flag
	sequence pin_wake_s;
		$rose(pin_wake_flag_o);
	endsequence
	sequence cmp_wake_s;
		$rose(comparator_wake_flag_o);
	endsequence
	// Device reset pulses on the same edge that records the cause
	sequence wake_rst_s;
		device_reset_o;
	endsequence
	por_flags_a: assert property ($rose(rst_n_i) |-> timeout_flag_o && powerdown_flag_o)
		else $error("flags wrong after power-up");
	sleep_flags_a: assert property (sleep_exec_i && !asleep_o && !device_reset_o
		|=> !powerdown_flag_o && timeout_flag_o) else $error("sleep flags wrong");
	asleep_hold_a: assert property (asleep_o |-> io_hold_o && !osc_drive_en_o)
		else $error("ports or oscillator not held in sleep");
	pin_cause_a: assert property (pin_wake_s |-> timeout_flag_o && !powerdown_flag_o
		&& !comparator_wake_flag_o) else $error("pin wake flags wrong");
	cmp_cause_a: assert property (cmp_wake_s |-> timeout_flag_o && !powerdown_flag_o
		&& !pin_wake_flag_o) else $error("comparator wake flags wrong");
	wake_reset_a: assert property (pin_wake_s or cmp_wake_s |-> wake_rst_s)
		else $error("no device reset after wake");
	wdt_wake_a: assert property (asleep_o && $fell(timeout_flag_o) |-> !powerdown_flag_o
		&& !pin_wake_flag_o && !comparator_wake_flag_o) else $error("wdt wake flags");
	bus_answer_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
		|=> !avs_waitrequest_o) else $error("bus answer late");
	bus_release_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("waitrequest low too long");
endmodule // swr_sleep_wake_chk
bind swr_sleep_wake swr_sleep_wake_chk chk_u (.*);
`default_nettype wire

// ---- tb/swr_far_model.sv ----
// Far side: core pulses, watched pins, comparator and clear pin.
// Assumes the block's system clock; levels change after an edge.
`timescale 1ns/10ps
`default_nettype none
module swr_far_model (
	input wire logic clk_sys_i,
	output logic sleep_exec_o,
	output logic port_access_o,
	output logic watched_pin_a_o,
	output logic watched_pin_b_o,
	output logic watched_pin_c_o,
	output logic comparator_out_o,
	output logic master_clear_pin_n_o
);
	logic [4:0] lv_q;
	// Clear pin idles high, all else low
	initial begin
		lv_q = 5'h10;
		sleep_exec_o = 1'b0;
		port_access_o = 1'b0;
	end
	assign {master_clear_pin_n_o, comparator_out_o} = lv_q[4:3];
	assign {watched_pin_c_o, watched_pin_b_o, watched_pin_a_o} = lv_q[2:0];
	// Pins read first so a stale mismatch cannot wake at once
	task automatic go_sleep(input logic read_first);
		if (read_first) begin
			@(posedge clk_sys_i);
			port_access_o <= 1'b1;
			@(posedge clk_sys_i);
			port_access_o <= 1'b0;
		end
		@(posedge clk_sys_i);
		sleep_exec_o <= 1'b1;
		@(posedge clk_sys_i);
		sleep_exec_o <= 1'b0;
	endtask
	task automatic flip(input logic [4:0] mask);
		@(posedge clk_sys_i);
		lv_q <= lv_q ^ mask;
	endtask
endmodule // swr_far_model
`default_nettype wire

// ---- tb/swr_sleep_wake_tb.sv ----
// Self-checking bench for the sleep, wake and reset-cause block.
// Assumes the far model drives pins; watchdog shortened to 20 clock cycles.
`timescale 1ns/10ps
`default_nettype none
module swr_sleep_wake_tb;
	import swr_pkg::*;
	logic clk, rst_n, slp, pacc, pa, pb, pc, cmpo, clr_n, rd, wr, wreq;
	logic [3:0] addr;
	logic [31:0] wdat, rdat, got, last_st;
	int errors, cmp_count, cycles;
	swr_sleep_wake #(.WDT_CYCLES(32'h14)) dut_u (.clk_sys_i(clk),
		.rst_n_i(rst_n), .sleep_exec_i(slp), .wdt_clear_i(1'b0),
		.port_access_i(pacc), .watched_pin_a_i(pa), .watched_pin_b_i(pb),
		.watched_pin_c_i(pc), .comparator_out_i(cmpo),
		.master_clear_pin_n_i(clr_n), .avs_address_i(addr), .avs_read_i(rd),
		.avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(4'hf),
		.avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .device_reset_o(),
		.osc_drive_en_o(), .io_hold_o(), .asleep_o(), .timeout_flag_o(),
		.powerdown_flag_o(), .pin_wake_flag_o(), .comparator_wake_flag_o());
	swr_far_model far_u (.clk_sys_i(clk), .sleep_exec_o(slp),
		.port_access_o(pacc), .watched_pin_a_o(pa), .watched_pin_b_o(pb),
		.watched_pin_c_o(pc), .comparator_out_o(cmpo),
		.master_clear_pin_n_o(clr_n));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Hang guard, well above the whole run
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 8000) begin
			errors++;
			give_verdict();
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// One bus access, held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		rd <= !w;
		wr <= w;
		addr <= a;
		wdat <= d;
		do @(posedge clk); while (wreq !== 1'b0);
		got = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		check(got, exp);
		// Wake flags survive sleep entry, so later naps need the last status
		if (a == REG_STATUS_OFS) last_st = exp;
	endtask
	// Asleep level with a bounded wait
	task automatic wait_for(input logic lvl);
		int n;
		n = 0;
		while (dut_u.asleep_o !== lvl && n < 200) begin
			@(posedge clk);
			n++;
		end
		if (n == 200) begin
			errors++;
			$display("ERROR %0t sleep state stuck", $time);
		end
	endtask
	// Modes: 0 change in sleep, 1 change before, 2 clear pulse, 3 watchdog
	task automatic nap(input int m, input logic [4:0] fl, input logic [31:0] exp);
		bus(1'b1, REG_CTRL_OFS, (m == 3) ? 32'h87 : 32'h86);
		if (m == 1) far_u.flip(fl);
		far_u.go_sleep(m != 1);
		if (m != 1) begin
			wait_for(1'b1);
			rd_chk(REG_STATUS_OFS, (last_st & 32'h0c) | 32'h12);
			far_u.flip(fl);
		end
		if (m == 2) begin
			repeat (4) @(posedge clk);
			far_u.flip(fl);
		end
		wait_for(1'b0);
		repeat (10) @(posedge clk);
		rd_chk(REG_STATUS_OFS, exp);
	endtask
	initial begin
		{rst_n, rd, wr, addr, wdat, errors, cmp_count, cycles} = '0;
		last_st = 32'h0;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		rd_chk(REG_STATUS_OFS, 32'h3);
		rd_chk(REG_CTRL_OFS, 32'hff);
		rd_chk(4'hc, 32'h0);
		bus(1'b1, REG_STATUS_OFS, 32'hff);
		rd_chk(REG_STATUS_OFS, 32'h3);
		nap(0, 5'h01, 32'h06);
		nap(0, 5'h08, 32'h0a);
		nap(1, 5'h04, 32'h06);
		far_u.flip(5'h10);
		repeat (4) @(posedge clk);
		far_u.flip(5'h10);
		repeat (10) @(posedge clk);
		rd_chk(REG_STATUS_OFS, 32'h02);
		nap(2, 5'h10, 32'h02);
		nap(3, 5'h00, 32'h00);
		rst_n <= 1'b0;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		rd_chk(REG_STATUS_OFS, 32'h3);
		// Awake time-out from power-up flags: powerdown must stay set
		bus(1'b1, REG_CTRL_OFS, 32'h87);
		repeat (40) @(posedge clk);
		bus(1'b1, REG_CTRL_OFS, 32'h86);
		rd_chk(REG_STATUS_OFS, 32'h01);
		give_verdict();
	end
endmodule // swr_sleep_wake_tb
`default_nettype wire
